//--- inc/lbg_pkg.sv
`default_nettype none
package lbg_pkg;
  // ----------------------------------------
  // Operating modes, trigger sources, units
  // ----------------------------------------
  typedef enum logic [1:0] {
    LBG_CW     = 2'b00,
    LBG_PULSED = 2'b01,
    LBG_BURST  = 2'b10
  } lbg_mode_t;

  typedef enum logic [1:0] {
    LBG_SRC_INT  = 2'b00,
    LBG_SRC_RISE = 2'b01,
    LBG_SRC_FALL = 2'b10
  } lbg_src_t;

  typedef enum logic [1:0] {
    LBG_UNIT_MHZ = 2'b00,
    LBG_UNIT_KHZ = 2'b01,
    LBG_UNIT_HZ  = 2'b10
  } lbg_unit_t;

  // ----------------------------------------
  // Widths and scale factors
  // ----------------------------------------
  localparam int LBG_NW = 64;                           // Divider numerator width
  localparam int LBG_DW = 40;                           // Divider denominator width
  localparam logic [63:0] LBG_CLK_HZ    = 64'h0000_0000_0EE6_B280; // 250 MHz
  localparam logic [39:0] LBG_MULT_MHZ  = 40'h00_000F_4240;
  localparam logic [39:0] LBG_MULT_KHZ  = 40'h00_0000_03E8;
  localparam logic [39:0] LBG_MULT_HZ   = 40'h00_0000_0001;
  localparam logic [63:0] LBG_NS_PER_S  = 64'h0000_0000_3B9A_CA00;
  localparam logic [63:0] LBG_DUTY_FULL = 64'h0000_0000_0000_2710; // 100.00 %

  // ----------------------------------------
  // Threshold range in millivolts, burst reset values
  // ----------------------------------------
  localparam logic signed [11:0] LBG_THR_MAX = 12'sh3E8;  // +1.000 V
  localparam logic signed [11:0] LBG_THR_MIN = 12'shC18;  // -1.000 V
  localparam logic [31:0] LBG_PER_RST = 32'h0000_0002;
  localparam logic [31:0] LBG_LEN_RST = 32'h0000_0001;
endpackage
`default_nettype wire

//--- inc/lbg_div_if.sv
`timescale 1ns/1ps
`default_nettype none
// Request and answer of the shared sequential divider
interface lbg_div_if;
  import lbg_pkg::*;
  logic              start;
  logic [LBG_NW-1:0] num;
  logic [LBG_DW-1:0] den;
  logic              done;
  logic [LBG_NW-1:0] quo;
  modport cli (output start, num, den, input done, quo);
  modport srv (input start, num, den, output done, quo);
endinterface // lbg_div_if
`default_nettype wire

//--- logic/lbg_div.sv
`timescale 1ns/1ps
`default_nettype none
// Restoring divider, one quotient bit per cycle; zero divisor gives all ones
module lbg_div
  import lbg_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_i,
  // Request and answer
  lbg_div_if.srv    d
);
  logic [LBG_DW:0]   rem_r;
  logic [LBG_NW-1:0] q_r;
  logic [6:0]        cnt_r;
  logic              busy_r;
  logic              done_r;
  logic [LBG_DW:0]   trial;

  // Next partial remainder
  assign trial = {rem_r[LBG_DW-1:0], q_r[LBG_NW-1]};

  // ----------------------------------------
  // Iteration
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rem_r  <= '0;
      q_r    <= '0;
      cnt_r  <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (d.start && !busy_r) begin
        rem_r  <= '0;
        q_r    <= d.num;
        cnt_r  <= 7'(LBG_NW);
        busy_r <= 1'b1;
      end else if (busy_r) begin
        if (trial >= {1'b0, d.den}) begin
          rem_r <= trial - {1'b0, d.den};
          q_r   <= {q_r[LBG_NW-2:0], 1'b1};
        end else begin
          rem_r <= trial;
          q_r   <= {q_r[LBG_NW-2:0], 1'b0};
        end
        cnt_r <= cnt_r - 7'h01;
        if (cnt_r == 7'h01) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end

  assign d.done = done_r;
  assign d.quo  = q_r;
endmodule // lbg_div
`default_nettype wire

//--- logic/lbg_top.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1 - Continuous-wave mode uses gating only and ignores trigger source and rate.
// R2 - Pulsed mode triggers from the internal oscillator or a rising or falling external edge.
// R3 - The internal oscillator runs at a rate given as a value in MHz, kHz or Hz.
// R4 - The external edge is found against a threshold held between -1 V and +1 V.
// R5 - Fast and slow gates are enabled independently and may both be active.
// R6 - The fast gate termination is selectable between 10 kilohm and 50 ohm.
// R7 - Burst mode uses the internal source only and selects it by itself.
// R8 - Bursts start a programmed number of trigger pulses apart.
// R9 - Each burst emits exactly its length in pulses and then stays silent to period end.
// R10 - Burst settings apply only when period exceeds length, else the old ones stay.
// R11 - Duty cycle, burst duration, burst rate and period duration are recomputed on change.
// R12 - A blocking enabled gate suppresses output while trigger and burst counting go on.
module lbg_top
  import lbg_pkg::*;
(
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               reset_i,
  // Mode and trigger settings
  input  wire logic [1:0]         mode_i,
  input  wire logic [1:0]         trig_src_i,
  input  wire logic [15:0]        rate_val_i,
  input  wire logic [1:0]         rate_unit_i,
  input  wire logic signed [11:0] thr_mv_i,
  // Gate settings and inputs (input high = pass)
  input  wire logic               fg_en_i,
  input  wire logic               sg_en_i,
  input  wire logic               fg_term50_i,
  input  wire logic               fg_i,
  input  wire logic               sg_i,
  // External trigger comparator result
  input  wire logic               ext_cmp_i,
  // Burst settings
  input  wire logic [31:0]        burst_per_i,
  input  wire logic [31:0]        burst_len_i,
  // Laser head side
  output logic                    laser_pulse_o,
  output logic                    laser_cw_o,
  output logic signed [11:0]      thr_mv_o,
  output logic                    fg_term50_o,
  // Status
  output logic [1:0]              src_o,
  output logic                    cfg_err_o,
  output logic                    calc_busy_o,
  output logic [31:0]             duty_o,
  output logic [31:0]             bdur_ns_o,
  output logic [31:0]             bfreq_hz_o,
  output logic [31:0]             pdur_ns_o
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_OSC  = 3'b001,
    S_DUTY = 3'b010,
    S_BDUR = 3'b011,
    S_BFRQ = 3'b100,
    S_PDUR = 3'b101
  } lbg_seq_t;

  // Saturate a quotient into a 32-bit result
  function automatic logic [31:0] sat32(input logic [63:0] v);
    sat32 = (v[63:32] != 32'h0) ? 32'hFFFF_FFFF : v[31:0];
  endfunction

  lbg_div_if div ();
  lbg_div u_div (.clk_i(clk_i), .reset_i(reset_i), .d(div));

  // ----------------------------------------
  // Settings capture
  // ----------------------------------------
  logic [39:0] mult;
  logic [39:0] rate_hz_r;
  logic [31:0] per_r;
  logic [31:0] len_r;
  logic        cfg_ok;
  logic [1:0]  eff_src;

  // Unit scaling of the rate value
  always_comb begin
    case (rate_unit_i)
      LBG_UNIT_MHZ: mult = LBG_MULT_MHZ;
      LBG_UNIT_KHZ: mult = LBG_MULT_KHZ;
      default:      mult = LBG_MULT_HZ;
    endcase
  end

  assign cfg_ok  = burst_per_i > burst_len_i; // R10
  // Burst forces the internal source
  assign eff_src = (mode_i == LBG_BURST) ? LBG_SRC_INT : trig_src_i; // R7

  // Rate register feeds both oscillator and calculations
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rate_hz_r <= '0;
    end else begin
      rate_hz_r <= 40'(rate_val_i) * mult; // R3
    end
  end

  // Burst configuration held until a valid pair arrives
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      per_r     <= LBG_PER_RST;
      len_r     <= LBG_LEN_RST;
      cfg_err_o <= 1'b0;
    end else begin
      cfg_err_o <= !cfg_ok;
      if (cfg_ok) begin
        per_r <= burst_per_i; // R10
        len_r <= burst_len_i; // R10
      end
    end
  end

  // Threshold clamp and termination select
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      thr_mv_o    <= '0;
      fg_term50_o <= 1'b0;
      src_o       <= LBG_SRC_INT;
    end else begin
      if (thr_mv_i > LBG_THR_MAX) thr_mv_o <= LBG_THR_MAX; // R4
      else if (thr_mv_i < LBG_THR_MIN) thr_mv_o <= LBG_THR_MIN; // R4
      else thr_mv_o <= thr_mv_i;
      fg_term50_o <= fg_term50_i; // R6
      src_o       <= eff_src;
    end
  end

  // ----------------------------------------
  // Trigger generation
  // ----------------------------------------
  logic [31:0] osc_per_r;
  logic [31:0] osc_cnt_r;
  logic        cmp_q_r;
  logic        tick;
  logic        trig;

  // A zero period means a zero rate or none computed yet; oscillator stays quiet
  assign tick = (osc_per_r != 32'h0) && (osc_cnt_r >= osc_per_r - 32'h1);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      osc_cnt_r <= '0;
    end else if (tick) begin
      osc_cnt_r <= '0;
    end else begin
      osc_cnt_r <= osc_cnt_r + 32'h1; // R3
    end
  end

  // Comparator history for edge detection
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cmp_q_r <= 1'b0;
    end else begin
      cmp_q_r <= ext_cmp_i;
    end
  end

  // Source select
  always_comb begin
    case (eff_src)
      LBG_SRC_RISE: trig = ext_cmp_i && !cmp_q_r; // R2
      LBG_SRC_FALL: trig = !ext_cmp_i && cmp_q_r; // R2
      default:      trig = tick; // R2
    endcase
  end

  // ----------------------------------------
  // Burst counting and output
  // ----------------------------------------
  logic [31:0] bpos_r;
  logic        gate_ok;
  logic        in_burst;
  logic        pulse_nxt;

  assign gate_ok  = (!fg_en_i || fg_i) && (!sg_en_i || sg_i); // R5
  assign in_burst = bpos_r < len_r;

  // Position within period, counted in triggers regardless of gates
  always_ff @(posedge clk_i) begin
    if (reset_i || mode_i != LBG_BURST) begin
      bpos_r <= '0;
    end else if (trig) begin
      if (bpos_r >= per_r - 32'h1) bpos_r <= '0; // R8
      else bpos_r <= bpos_r + 32'h1; // R12
    end
  end

  always_comb begin
    pulse_nxt = 1'b0;
    if (mode_i == LBG_PULSED) pulse_nxt = trig && gate_ok; // R12
    else if (mode_i == LBG_BURST) pulse_nxt = trig && gate_ok && in_burst; // R9
  end

  // CW mode: gates alone drive emission
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      laser_pulse_o <= 1'b0;
      laser_cw_o    <= 1'b0;
    end else begin
      laser_pulse_o <= pulse_nxt;
      laser_cw_o    <= (mode_i == LBG_CW) && gate_ok; // R1
    end
  end

  // ----------------------------------------
  // Derived figures
  // ----------------------------------------
  lbg_seq_t    seq_r;
  logic        wait_r;
  logic        start_r;
  logic [39:0] c_rate_r;
  logic [31:0] c_per_r;
  logic [31:0] c_len_r;
  logic        chg;

  assign chg = (rate_hz_r != c_rate_r) || (per_r != c_per_r) || (len_r != c_len_r);

  // Operands per step
  always_comb begin
    div.num = LBG_CLK_HZ;
    div.den = c_rate_r;
    case (seq_r)
      S_DUTY: begin
        div.num = 64'(c_len_r) * LBG_DUTY_FULL;
        div.den = 40'(c_per_r);
      end
      S_BDUR: div.num = 64'(c_len_r) * LBG_NS_PER_S;
      S_BFRQ: begin
        div.num = 64'(c_rate_r);
        div.den = 40'(c_per_r);
      end
      S_PDUR: div.num = 64'(c_per_r) * LBG_NS_PER_S;
      default: ;
    endcase
  end
  assign div.start = start_r;

  // Sequencer; a change during a pass is caught by the next one
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      seq_r <= S_IDLE;
      wait_r <= 1'b0;
      start_r <= 1'b0;
      c_rate_r <= '0;
      c_per_r <= '0;
      c_len_r <= '0;
      osc_per_r <= '0;
      duty_o <= '0;
      bdur_ns_o <= '0;
      bfreq_hz_o <= '0;
      pdur_ns_o <= '0;
    end else begin
      start_r <= 1'b0;
      case (seq_r)
        S_IDLE: begin
          if (chg) begin
            c_rate_r <= rate_hz_r;
            c_per_r  <= per_r;
            c_len_r  <= len_r;
            seq_r    <= S_OSC; // R11
          end
        end
        default: begin
          if (!wait_r) begin
            wait_r  <= 1'b1;
            start_r <= 1'b1;
          end else if (div.done) begin
            wait_r <= 1'b0;
            case (seq_r)
              S_OSC: begin
                // Rates above the clock floor to one tick per cycle
                osc_per_r <= (c_rate_r == '0) ? 32'h0 :
                             (div.quo == '0) ? 32'h1 : sat32(div.quo); // R3
                seq_r <= S_DUTY;
              end
              S_DUTY: begin
                duty_o <= sat32(div.quo); // R11
                seq_r <= S_BDUR;
              end
              S_BDUR: begin
                bdur_ns_o <= sat32(div.quo); // R11
                seq_r <= S_BFRQ;
              end
              S_BFRQ: begin
                bfreq_hz_o <= sat32(div.quo); // R11
                seq_r <= S_PDUR;
              end
              default: begin
                pdur_ns_o <= sat32(div.quo); // R11
                seq_r <= S_IDLE;
              end
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) calc_busy_o <= 1'b0;
    else calc_busy_o <= (seq_r != S_IDLE) || chg;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_cw_no_pulse: assert property ((mode_i == LBG_CW) |=> !laser_pulse_o) // R1
    else $error("pulse emitted in cw mode");
  a_ext_edge_fire: assert property ((mode_i == LBG_PULSED && trig_src_i == LBG_SRC_RISE
    && ext_cmp_i && !cmp_q_r && gate_ok) |=> laser_pulse_o) // R2
    else $error("rising edge not turned into pulse");
  a_osc_spacing: assert property ((tick && osc_per_r > 32'h1 && $stable(osc_per_r))
    |=> !tick) // R3
    else $error("oscillator ticks too close");
  a_thr_clamped: assert property (thr_mv_o <= LBG_THR_MAX && thr_mv_o >= LBG_THR_MIN) // R4
    else $error("threshold out of range");
  a_gate_blocks: assert property (((fg_en_i && !fg_i) || (sg_en_i && !sg_i))
    |=> !laser_pulse_o && !laser_cw_o) // R12
    else $error("output while gate blocks");
  a_term_follow: assert property (##1 fg_term50_o == $past(fg_term50_i)) // R6
    else $error("termination select not followed");
  a_burst_int: assert property ((mode_i == LBG_BURST) |=> src_o == LBG_SRC_INT) // R7
    else $error("burst without internal source");
  a_burst_wrap: assert property ((mode_i == LBG_BURST && trig && bpos_r >= per_r - 32'h1)
    ##1 (mode_i == LBG_BURST) |-> bpos_r == 32'h0) // R8
    else $error("burst period did not restart");
  a_burst_silent: assert property ((mode_i == LBG_BURST && !in_burst) |=> !laser_pulse_o) // R9
    else $error("pulse outside burst");
  a_cfg_keep: assert property (!cfg_ok |=> $stable(per_r) && $stable(len_r) && cfg_err_o) // R10
    else $error("invalid burst setting applied");
  a_recalc_start: assert property ((seq_r == S_IDLE && chg) |=> seq_r == S_OSC
    ##[1:80] seq_r == S_DUTY) // R11
    else $error("derived figures not recomputed");

  c_burst_pulse: cover property (mode_i == LBG_BURST ##1 laser_pulse_o);
  c_fall_pulse: cover property (trig_src_i == LBG_SRC_FALL && mode_i == LBG_PULSED
    ##1 laser_pulse_o);
  c_cfg_reject: cover property (cfg_err_o);
  c_calc_done: cover property (seq_r == S_PDUR ##1 seq_r == S_IDLE);
endmodule // lbg_top
`default_nettype wire

//--- test/lbg_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// External trigger source behind the comparator
// ----------------------------------------
module lbg_far_model
  import lbg_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // Train request: number of level changes
  input  wire logic       go_i,
  input  wire logic [7:0] n_edges_i,
  // Comparator output towards the block
  output logic            ext_cmp_o
);
  logic [7:0] left_r;
  logic [1:0] pace_r;

  // Level change every 4 cycles; an odd train leaves the line inverted
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      left_r    <= 8'h00;
      pace_r    <= 2'h0;
      ext_cmp_o <= 1'b0;
    end else if (go_i) begin
      left_r <= n_edges_i;
      pace_r <= 2'h0;
    end else if (left_r != 8'h00) begin
      pace_r <= pace_r + 2'h1;
      if (pace_r == 2'h3) begin
        ext_cmp_o <= ~ext_cmp_o;
        left_r    <= left_r - 8'h01;
      end
    end
  end
endmodule // lbg_far_model
`default_nettype wire

//--- test/laser_trigger_burst_gating_bench.sv
`timescale 1ns/1ps
`default_nettype none
module laser_trigger_burst_gating_bench
  import lbg_pkg::*;
;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic               clk_i = 1'b0;
  logic               reset_i = 1'b1;
  logic [1:0]         mode_i = 2'h0, trig_src_i = 2'h0, rate_unit_i = 2'h0;
  logic [15:0]        rate_val_i = 16'h000A;
  logic signed [11:0] thr_mv_i = 12'sh000;
  logic               fg_en_i = 1'b0, sg_en_i = 1'b0, fg_i = 1'b1, sg_i = 1'b1;
  logic               fg_term50_i = 1'b0;
  logic [31:0]        burst_per_i = 32'h2, burst_len_i = 32'h1;
  wire logic          ext_cmp_i;
  logic               laser_pulse_o, laser_cw_o, fg_term50_o, cfg_err_o, calc_busy_o;
  logic signed [11:0] thr_mv_o;
  logic [1:0]         src_o;
  logic [31:0]        duty_o, bdur_ns_o, bfreq_hz_o, pdur_ns_o, pulse_cnt;
  logic               go = 1'b0, win_clr = 1'b0, win_end = 1'b0;
  logic [7:0]         n_edges = 8'h00;
  logic [31:0]        exp_q[$];
  logic [15:0]        rv_t[3] = '{16'h0032, 16'h61A8, 16'hF424};
  int                 per_t[3] = '{5, 10, 4000};
  int                 bad_count = 0, num_checks = 0;

  lbg_top u_dut (.clk_i, .reset_i, .mode_i, .trig_src_i, .rate_val_i, .rate_unit_i,
    .thr_mv_i, .fg_en_i, .sg_en_i, .fg_term50_i, .fg_i, .sg_i, .ext_cmp_i,
    .burst_per_i, .burst_len_i, .laser_pulse_o, .laser_cw_o, .thr_mv_o, .fg_term50_o,
    .src_o, .cfg_err_o, .calc_busy_o, .duty_o, .bdur_ns_o, .bfreq_hz_o, .pdur_ns_o);

  lbg_far_model u_far (.clk_i, .reset_i, .go_i(go), .n_edges_i(n_edges),
    .ext_cmp_o(ext_cmp_i));

  // 250 MHz
  initial forever #2 clk_i = ~clk_i;

  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    if (bad_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Pulse count per window; compared against the oldest note when a window closes
  always @(posedge clk_i) begin
    if (win_end) chk("pulse count", exp_q.pop_front(), pulse_cnt);
    if (win_clr) pulse_cnt = 32'h0;
    else if (laser_pulse_o === 1'b1) pulse_cnt++;
  end

  // ----------------------------------------
  // Drivers
  // ----------------------------------------
  task automatic win(input int n, input logic [31:0] exp);
    @(posedge clk_i);
    exp_q.push_back(exp);
    win_clr <= 1'b1;
    @(posedge clk_i);
    win_clr <= 1'b0;
    repeat (n) @(posedge clk_i);
    win_end <= 1'b1;
    @(posedge clk_i);
    win_end <= 1'b0;
  endtask

  // Window spans the whole train, so phase does not matter
  task automatic train(input int n, input logic [31:0] exp);
    fork
      win(4 * n + 24, exp);
      begin
        repeat (3) @(posedge clk_i);
        go      <= 1'b1;
        n_edges <= 8'(n);
        @(posedge clk_i);
        go      <= 1'b0;
      end
    join
  endtask

  // Waits for the derived figures and oscillator period to be recomputed
  task automatic cfg(input logic [1:0] m, s, input logic [15:0] rv, input logic [1:0] ru,
                     input logic [31:0] p, l);
    int k;
    @(posedge clk_i);
    mode_i      <= m;
    trig_src_i  <= s;
    rate_val_i  <= rv;
    rate_unit_i <= ru;
    burst_per_i <= p;
    burst_len_i <= l;
    k = 0;
    repeat (4) @(posedge clk_i);
    while (calc_busy_o !== 1'b0 && k < 3000) begin
      @(posedge clk_i);
      k++;
    end
    #1;
    // A pass that never ends shows up here as a mismatch
    chk("calc_busy", 32'h0, {31'h0, calc_busy_o});
  endtask

  function automatic logic [11:0] clamp(input logic signed [11:0] v);
    if (v > LBG_THR_MAX) return LBG_THR_MAX;
    if (v < LBG_THR_MIN) return LBG_THR_MIN;
    return v;
  endfunction

  // Hang guard, well above the expected run length
  initial begin
    repeat (60000) @(posedge clk_i);
    bad_count++;
    tally_and_finish();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    logic signed [11:0] v;
    void'($urandom(76050));
    repeat (20) @(posedge clk_i);
    #1 chk("src", 32'h0, {30'h0, src_o});
    chk("cw", 32'h0, {31'h0, laser_cw_o});
    @(posedge clk_i);
    reset_i <= 1'b0;
    fg_en_i <= 1'b1;
    sg_en_i <= 1'b1;
    // Threshold clamp and termination copy, edges of the code range first
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 12'sh800 : (i == 1) ? 12'sh7FF : 12'($urandom);
      @(posedge clk_i);
      thr_mv_i    <= v;
      fg_term50_i <= 1'($urandom);
      repeat (2) @(posedge clk_i);
      #1 chk("thr", {20'h0, clamp(v)}, {20'h0, thr_mv_o});
      chk("term", {31'h0, fg_term50_i}, {31'h0, fg_term50_o});
    end
    // Continuous wave: gating only, edges ignored
    cfg(LBG_CW, LBG_SRC_RISE, 16'h000A, LBG_UNIT_MHZ, 32'h4, 32'h2);
    chk("cw", 32'h1, {31'h0, laser_cw_o});
    // Even train so the line is low again for the pulsed edges
    train(4, 32'h0);
    @(posedge clk_i);
    fg_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1 chk("cw", 32'h0, {31'h0, laser_cw_o});
    fg_i <= 1'b1;
    // Pulsed, external edges: 5 changes from low hold 3 rises
    cfg(LBG_PULSED, LBG_SRC_RISE, 16'h000A, LBG_UNIT_MHZ, 32'h4, 32'h2);
    chk("src", {30'h0, LBG_SRC_RISE}, {30'h0, src_o});
    train(5, 32'h3);
    // 3 changes from high hold 2 falls
    cfg(LBG_PULSED, LBG_SRC_FALL, 16'h000A, LBG_UNIT_MHZ, 32'h4, 32'h2);
    train(3, 32'h2);
    cfg(LBG_PULSED, LBG_SRC_RISE, 16'h000A, LBG_UNIT_MHZ, 32'h4, 32'h2);
    fg_i <= 1'b0;
    train(4, 32'h0);
    fg_en_i <= 1'b0;
    sg_i    <= 1'b0;
    // Slow gate alone still enabled and blocking
    train(4, 32'h0);
    sg_en_i <= 1'b0;
    train(4, 32'h2);
    fg_en_i <= 1'b1;
    sg_en_i <= 1'b1;
    fg_i    <= 1'b1;
    sg_i    <= 1'b1;
    train(4, 32'h2);
    // Internal oscillator in each unit
    for (int i = 0; i < 3; i++) begin
      cfg(LBG_PULSED, LBG_SRC_INT, rv_t[i], 2'(i), 32'h4, 32'h2);
      chk("src", {30'h0, LBG_SRC_INT}, {30'h0, src_o});
      win(6 * per_t[i], 32'h6);
    end
    // Burst at 10 MHz: 25 cycles per trigger
    cfg(LBG_BURST, LBG_SRC_RISE, 16'h000A, LBG_UNIT_MHZ, 32'h4, 32'h2);
    chk("src", {30'h0, LBG_SRC_INT}, {30'h0, src_o});
    chk("duty", 32'h1388, duty_o);
    chk("bdur", 32'h00C8, bdur_ns_o);
    chk("bfreq", 32'h0026_25A0, bfreq_hz_o);
    chk("pdur", 32'h0190, pdur_ns_o);
    win(200, 32'h4);
    // Period equal to length is refused; old pair keeps running
    cfg(LBG_BURST, LBG_SRC_INT, 16'h000A, LBG_UNIT_MHZ, 32'h3, 32'h3);
    chk("cfg_err", 32'h1, {31'h0, cfg_err_o});
    win(200, 32'h4);
    cfg(LBG_BURST, LBG_SRC_INT, 16'h000A, LBG_UNIT_MHZ, 32'h5, 32'h1);
    chk("cfg_err", 32'h0, {31'h0, cfg_err_o});
    chk("duty", 32'h07D0, duty_o);
    chk("pdur", 32'h01F4, pdur_ns_o);
    win(250, 32'h2);
    @(posedge clk_i);
    fg_i <= 1'b0;
    win(250, 32'h0);
    tally_and_finish();
  end
endmodule // laser_trigger_burst_gating_bench
`default_nettype wire
